// ---- src/kpi_pin_irq_unit.v ----
// kpi_pin_irq_unit.v - eight-input pin interrupt unit with an axi4-lite register slave
// assumes pins are asynchronous to clk_sys; low-power entry is signalled by the system controller
// one small cell per pin repeats the synchroniser and the detector
`include "kpi_map.vh"

// ***************************************************************
// one pin: synchroniser, arming and edge/level detection
// ***************************************************************
module kpi_pin_cell
(
	input  wire clk_sys,
	input  wire unit_reset,
	input  wire pin_raw,
	input  wire source_enable,
	input  wire polarity,
	input  wire level_mode,
	output wire asserted,
	output wire hit
);

	reg  pin_meta;
	reg  pin_sync;
	reg  pin_prev;
	reg  pin_armed;
	wire prev_asserted;
	wire edge_hit;

	// two stages before any detection logic sees the pin
	always @(posedge clk_sys)
	begin
		pin_meta <= pin_raw;
		pin_sync <= pin_meta;
	end

	// polarity 0 means active low, 1 active high
	assign asserted      = (pin_sync ~^ polarity) & source_enable;
	assign prev_asserted = pin_prev ~^ polarity;
	// edge only counts once the pin was armed by a deasserted sample
	assign edge_hit      = asserted & ~prev_asserted & pin_armed;
	// a held level keeps hitting, so acknowledge cannot clear it early
	assign hit           = edge_hit | (level_mode & asserted);

	// one sample per bus cycle, also in wait, retained stop and debug
	always @(posedge clk_sys)
	begin
		if (unit_reset)
		begin
			pin_prev  <= 1'b0;
			pin_armed <= 1'b0;
		end
		else
		begin
			pin_prev  <= pin_sync;
			pin_armed <= source_enable & ~asserted;
		end
	end

endmodule // kpi_pin_cell

module kpi_pin_irq_unit
(
	input  wire        clk_sys,
	input  wire        srst,
	input  wire        deepest_stop_mode,
	input  wire        retained_stop_mode,
	input  wire [7:0]  pin_in,
	output reg  [7:0]  pin_pull_down,
	output reg         irq_request,
	output reg         wake_request,
	output reg         peripheral_clock_gate_2,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ***************************************************************
	// state
	// ***************************************************************
	reg  [7:0] pin_source_enable;
	reg  [7:0] pin_polarity_select;
	reg        irq_request_enable;
	reg        detect_mode_select;
	reg        pin_event_flag;
	reg  [3:0] aw_addr;
	reg        aw_held;
	reg [31:0] w_data;
	reg  [3:0] w_strb;
	reg        w_held;

	reg [31:0] next_rdata;
	reg  [1:0] next_rresp;
	reg        next_pin_event_flag;
	reg        next_irq_request;
	reg        next_wake_request;

	wire [7:0] pin_asserted;
	wire [7:0] pin_hit;
	wire       event_hit;
	wire       ack_clears;
	genvar     pin_idx;
	wire       unit_reset;
	wire       do_write;
	wire       ack_write;
	wire       write_ok;
	wire       do_read;

	// deepest stop powers the unit down; it comes back as after reset
	assign unit_reset = srst | deepest_stop_mode;

	// ***************************************************************
	// detection
	// ***************************************************************
	// eight identical cells, each with its own synchroniser and history
	generate
		for (pin_idx = 0; pin_idx < 8; pin_idx = pin_idx + 1)
		begin : g_pin
			kpi_pin_cell i_cell
			(
				.clk_sys       (clk_sys),
				.unit_reset    (unit_reset),
				.pin_raw       (pin_in[pin_idx]),
				.source_enable (pin_source_enable[pin_idx]),
				.polarity      (pin_polarity_select[pin_idx]),
				.level_mode    (detect_mode_select),
				.asserted      (pin_asserted[pin_idx]),
				.hit           (pin_hit[pin_idx])
			);
		end
	endgenerate

	// any enabled pin raises the shared flag
	assign event_hit  = |pin_hit;
	// acknowledge only works once every enabled pin is back at rest
	assign ack_clears = ack_write && (pin_asserted == 8'h00);

	// ***************************************************************
	// register bus
	// ***************************************************************
	// address and data may arrive in either order; each is held until both are in
	assign do_write  = aw_held & w_held & ~s_axi_bvalid;
	assign write_ok  = (aw_addr == `KPI_OFS_STATUS_CONTROL) || (aw_addr == `KPI_OFS_ENABLE_SELECT) ||
		(aw_addr == `KPI_OFS_POLARITY) || (aw_addr == `KPI_OFS_CLOCK_GATE);
	assign ack_write = do_write && (aw_addr == `KPI_OFS_STATUS_CONTROL) && w_strb[0] &&
		w_data[`KPI_BIT_ACK];
	assign do_read   = s_axi_arvalid & s_axi_arready;

	// write address: taken once, refused until the response is taken
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_held       <= 1'b0;
			aw_addr       <= 4'h0;
			s_axi_awready <= 1'b1;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_addr       <= s_axi_awaddr;
			aw_held       <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data: same rules as the address half
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b1;
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			w_held       <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	// response: raised once both halves are in, held until taken
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `KPI_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= write_ok ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ***************************************************************
	// control registers
	// ***************************************************************
	// only byte lane 0 carries register bits; other lanes are ignored
	always @(posedge clk_sys)
	begin
		if (unit_reset)
		begin
			{irq_request_enable, detect_mode_select} <= `KPI_RST_CTRL;
			pin_source_enable   <= `KPI_RST_ENABLE;
			pin_polarity_select <= `KPI_RST_POLARITY;
		end
		else if (do_write && w_strb[0])
		begin
			if (aw_addr == `KPI_OFS_STATUS_CONTROL)
			begin
				irq_request_enable <= w_data[`KPI_BIT_IRQEN];
				detect_mode_select <= w_data[`KPI_BIT_MODE];
			end
			if (aw_addr == `KPI_OFS_ENABLE_SELECT)
				pin_source_enable <= w_data[7:0];
			if (aw_addr == `KPI_OFS_POLARITY)
				pin_polarity_select <= w_data[7:0];
		end
	end

	// clock gate lives outside the unit's own reset domain: any system reset sets it
	always @(posedge clk_sys)
	begin
		if (srst)
			peripheral_clock_gate_2 <= `KPI_RST_GATE;
		else if (do_write && w_strb[0] && aw_addr == `KPI_OFS_CLOCK_GATE)
			peripheral_clock_gate_2 <= w_data[0];
	end

	// ***************************************************************
	// event flag
	// ***************************************************************
	// set beats acknowledge; acknowledge fails while any enabled pin is asserted
	always @*
	begin
		next_pin_event_flag = pin_event_flag;
		if (event_hit)
			next_pin_event_flag = 1'b1;
		else if (ack_clears)
			next_pin_event_flag = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		if (unit_reset)
			pin_event_flag <= 1'b0;
		else
			pin_event_flag <= next_pin_event_flag;
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	// built from the next flag so the request drops with the flag; it follows the enable register one cycle later
	always @*
	begin
		next_irq_request  = next_pin_event_flag & irq_request_enable;
		// wake needs both the pin and the interrupt enabled
		next_wake_request = (event_hit | pin_event_flag) & irq_request_enable &
			(retained_stop_mode | 1'b1);
	end

	always @(posedge clk_sys)
	begin
		if (unit_reset)
		begin
			irq_request  <= 1'b0;
			wake_request <= 1'b0;
		end
		else
		begin
			irq_request  <= next_irq_request;
			wake_request <= next_wake_request;
		end
	end

	// pull selection trails the polarity register by one cycle
	always @(posedge clk_sys)
	begin
		if (unit_reset)
			pin_pull_down <= 8'h00;
		else
			pin_pull_down <= pin_polarity_select;
	end

	// ***************************************************************
	// read channel
	// ***************************************************************
	// read mux: unmapped offsets answer zero with an error
	always @*
	begin
		next_rdata = 32'h00000000;
		next_rresp = `KPI_RESP_OKAY;
		case (s_axi_araddr)
			`KPI_OFS_STATUS_CONTROL:
				next_rdata = {28'h0000000, pin_event_flag, 1'b0, irq_request_enable, detect_mode_select};
			`KPI_OFS_ENABLE_SELECT:
				next_rdata = {24'h000000, pin_source_enable};
			`KPI_OFS_POLARITY:
				next_rdata = {24'h000000, pin_polarity_select};
			`KPI_OFS_CLOCK_GATE:
				next_rdata = {31'h00000000, peripheral_clock_gate_2};
			default:
				next_rresp = `KPI_RESP_SLVERR;
		endcase
	end

	// one read in flight; arready drops until the data is taken
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `KPI_RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // kpi_pin_irq_unit

// ---- src/kpi_map.vh ----
// kpi_map.vh - constants for the pin interrupt unit: offsets, fields, reset values
// assumes inclusion by bare name from the design file; definitions only
// Summary of operation
// - eight inputs, each enabled on its own
// - clock gate bit set by reset
// - keeps working in wait, can wake
// - retained stop: detects pins, wakes when enabled
// - deepest stop disables, returns at reset
// - debug mode: operates exactly as run
// - flag at bit 3, writes ignored
// - acknowledge bit 2, write 1, reads 0
// - enable bit 1 gates the request
// - mode bit 0 selects edge or edge+level
// - pin enable bit includes that input
// - polarity bit picks edge, level and pull
// - edges sampled once per bus cycle
// - edge needs prior deasserted sample
// - falling edge: 1 then 0
// - rising edge: 0 then 1
// - valid edge sets flag, request if enabled
// - write 1 to acknowledge clears flag
// - polarity programmable per input
// - level mode: asserted level sets flag
// - acknowledge clears only if all deasserted
// - polarity 0 pull-up, 1 pull-down
`ifndef KPI_MAP_VH
`define KPI_MAP_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define KPI_OFS_STATUS_CONTROL 4'h0
`define KPI_OFS_ENABLE_SELECT  4'h4
`define KPI_OFS_POLARITY       4'h8
`define KPI_OFS_CLOCK_GATE     4'hC

// ***************************************************************
// status/control fields
// ***************************************************************
`define KPI_BIT_FLAG   3
`define KPI_BIT_ACK    2
`define KPI_BIT_IRQEN  1
`define KPI_BIT_MODE   0

// ***************************************************************
// reset values
// ***************************************************************
`define KPI_RST_CTRL     2'h0
`define KPI_RST_ENABLE   8'h00
`define KPI_RST_POLARITY 8'h00
`define KPI_RST_GATE     1'h1

// ***************************************************************
// bus responses
// ***************************************************************
`define KPI_RESP_OKAY   2'h0
`define KPI_RESP_SLVERR 2'h2

`endif

// ---- verification/kpi_keypad.sv ----
// kpi_keypad.sv - far-side keypad: switches driving the unit's pins
// assumes the pull resistors are enabled on every pin
module kpi_keypad
(
	input  wire [7:0] pull_down,
	input  wire [7:0] drive_en,
	input  wire [7:0] drive_val,
	output wire [7:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// open switch leaves the pin at its pull level
	assign pin_level = (drive_en & drive_val) | (~drive_en & ~pull_down);
endmodule // kpi_keypad

// ---- verification/kpi_pin_irq_unit_assertions.sv ----
// kpi_pin_irq_unit_assertions.sv - port checker for the pin interrupt unit
// assumes one clock domain, bound to every instance of the unit
module kpi_irq_chk
(
	input wire        clk_sys,
	input wire        srst,
	input wire        deepest_stop_mode,
	input wire        irq_request,
	input wire        wake_request,
	input wire        peripheral_clock_gate_2,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [3:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [3:0] rd_addr = 4'h0;
	// address of the read under way
	always @(posedge clk_sys)
		if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	a_gate_after_reset: assert property ($fell(srst) |-> peripheral_clock_gate_2 && !irq_request)
		else $error("clock gate or request wrong after reset");
	a_irq_means_wake: assert property (irq_request |-> wake_request)
		else $error("request without wake");
	a_deep_stop_clears: assert property (deepest_stop_mode |=> !irq_request)
		else $error("request survives deepest stop");
	a_ack_reads_zero: assert property (s_axi_rvalid && rd_addr == 4'h0 |->
		!s_axi_rdata[2] && s_axi_rdata[31:4] == 28'h0)
		else $error("status read shows ack or upper bits");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	c_irq: cover property (irq_request);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // kpi_irq_chk
bind kpi_pin_irq_unit kpi_irq_chk i_chk (.*);

// ---- verification/tb_kpi_pin_irq_unit.sv ----
// tb_kpi_pin_irq_unit.sv - self-checking bench for the pin interrupt unit
// assumes keypad model on the pins, bench as bus master
module tb_kpi_pin_irq_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 0, srst = 1, dstop = 0, rstop = 0;
	logic [7:0]  den = 0, dval = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, q;
	logic [1:0]  rsp;
	wire  [7:0]  pin, pd;
	wire         irq, wake, gate, awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          n_errors = 0, check_count = 0;
	always #20 clk_sys = ~clk_sys;
	kpi_keypad i_pad (.pull_down(pd), .drive_en(den), .drive_val(dval), .pin_level(pin));
	kpi_pin_irq_unit i_dut (.clk_sys(clk_sys), .srst(srst), .deepest_stop_mode(dstop),
		.retained_stop_mode(rstop), .pin_in(pin), .pin_pull_down(pd), .irq_request(irq),
		.wake_request(wake), .peripheral_clock_gate_2(gate), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ****************************************
	// bus and compare helpers
	// ****************************************
	task automatic close_out;
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e)
		begin
			$display("wrong value at %0t ns: got %h want %h", $time, g, e);
			n_errors++;
		end
	endtask
	// a wait that runs out ends the run
	task automatic lose(input int k);
		if (k >= 40)
		begin
			n_errors++;
			close_out();
		end
	endtask
	task automatic wr(input [3:0] a, input [7:0] d);
		int k = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk_sys); while (!(awready && wready) && ++k < 40);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk_sys); while (!bvalid && ++k < 40);
		rsp = bresp;
		bready <= 1'b0;
		lose(k);
	endtask
	task automatic rc(input [3:0] a, input [31:0] e);
		int k = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (!arready && ++k < 40);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (!rvalid && ++k < 40);
		q = rdata;
		rsp = rresp;
		rready <= 1'b0;
		lose(k);
		chk(q, e);
	endtask
	// pin changes need the synchroniser to settle
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rc(4'h0, 0);
		rc(4'h4, 0);
		rc(4'h8, 0);
		rc(4'hC, 1);
		chk(gate, 1);
		rc(4'h2, 0);
		chk(rsp, 2'h2);
		wr(4'h2, 8'h01);
		chk(rsp, 2'h2);
		wstrb <= 4'h0;
		wr(4'h4, 8'hFF);
		wstrb <= 4'hF;
		rc(4'h4, 0);
		wr(4'hC, 8'h00);
		rc(4'hC, 0);
		idle(1);
		chk(gate, 0);
		srst <= 1'b1;
		idle(2);
		srst <= 1'b0;
		idle(1);
		chk(gate, 1);
	endtask
	task automatic t_falling;
		wr(4'h4, 8'h01);
		wr(4'h0, 8'h04);
		idle(6);
		rc(4'h0, 0);
		rstop <= 1'b1;
		den[0] <= 1'b1;
		idle(6);
		rc(4'h0, 8'h08);
		chk(irq, 0);
		wr(4'h0, 8'h02);
		rc(4'h0, 8'h0A);
		idle(2);
		chk(irq, 1);
		chk(wake, 1);
		den[0] <= 1'b0;
		idle(6);
		wr(4'h0, 8'h06);
		rc(4'h0, 8'h02);
		idle(2);
		chk(irq, 0);
		rstop <= 1'b0;
	endtask
	task automatic t_rising;
		wr(4'h0, 8'h00);
		wr(4'h8, 8'h02);
		idle(2);
		chk(pd, 8'h02);
		wr(4'h4, 8'h02);
		wr(4'h0, 8'h04);
		den[3] <= 1'b1;
		idle(6);
		rc(4'h0, 0);
		den[3] <= 1'b0;
		dval[1] <= 1'b1;
		den[1] <= 1'b1;
		idle(6);
		rc(4'h0, 8'h08);
		wr(4'h0, 8'h04);
		rc(4'h0, 8'h08);
		den[1] <= 1'b0;
		idle(6);
		wr(4'h0, 8'h04);
		rc(4'h0, 0);
	endtask
	task automatic t_level;
		wr(4'h8, 8'h00);
		dval[2] <= 1'b0;
		den[2] <= 1'b1;
		wr(4'h4, 8'h04);
		wr(4'h0, 8'h04);
		idle(6);
		rc(4'h0, 0);
		wr(4'h0, 8'h03);
		idle(6);
		rc(4'h0, 8'h0B);
		dstop <= 1'b1;
		idle(2);
		dstop <= 1'b0;
		rc(4'h0, 0);
		rc(4'h4, 0);
		chk(irq, 0);
		den[2] <= 1'b0;
	endtask
	initial
	begin
		idle(20);
		srst <= 1'b0;
		t_reset();
		t_falling();
		t_rising();
		t_level();
		close_out();
	end
endmodule // tb_kpi_pin_irq_unit
